/* inc/wdc_map.svh */
`ifndef WDC_MAP_SVH
`define WDC_MAP_SVH

`define WDC_CTRL_ADDR 8'hD8
`define WDC_CTRL_RESET 8'hFE
`define WDC_ACT_BIT 0
`define WDC_SOFT_RESET_BIT 1
`define WDC_CLK_HZ 40000000
`define WDC_STEP_CYCLES 3072
`define WDC_PULSE_NS 500
`define WDC_PULSE_CYCLES ((`WDC_PULSE_NS * (`WDC_CLK_HZ / 1000000) + 999) / 1000)

`endif

/* inc/wdc_pkg.sv */
package wdc_pkg;
    typedef enum logic [1:0] {
        WDC_RUN,
        WDC_FROZEN
    } wdc_state_t;
    typedef enum logic [1:0] {
        WDC_STOP_NORMAL,
        WDC_STOP_AS_WAIT,
        WDC_STOP_FREEZE
    } wdc_stop_t;
endpackage : wdc_pkg

/* logic/wdc_step_divider.sv */
`include "wdc_map.svh"

module wdc_step_divider #(
    parameter int STEP_CYCLES = `WDC_STEP_CYCLES
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic resetn,
    // Control.
    input wire logic run,
    input wire logic restart,
    // Step.
    output logic stepPulse
);
    logic [15:0] divCnt_reg;

    // Freezing holds the partial count so a resumed step is not lost.
    always_ff @(posedge sys_clk) begin
        if (!resetn || restart) begin
            divCnt_reg <= 16'h0000;
        end else if (run) begin
            if (divCnt_reg == 16'(STEP_CYCLES - 1)) begin
                divCnt_reg <= 16'h0000;
            end else begin
                divCnt_reg <= divCnt_reg + 16'h0001;
            end
        end
    end

    assign stepPulse = run && !restart && (divCnt_reg == 16'(STEP_CYCLES - 1));
endmodule : wdc_step_divider

/* logic/wdc_reset_pulse.sv */
`include "wdc_map.svh"

module wdc_reset_pulse #(
    parameter int PULSE_CYCLES = `WDC_PULSE_CYCLES
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic resetn,
    // Trigger.
    input wire logic fire,
    // Reset pin.
    output logic resetPinN
);
    logic [7:0] pulseCnt_reg;

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            pulseCnt_reg <= 8'h00;
        end else if (fire && pulseCnt_reg == 8'h00) begin
            pulseCnt_reg <= 8'(PULSE_CYCLES);
        end else if (pulseCnt_reg != 8'h00) begin
            pulseCnt_reg <= pulseCnt_reg - 8'h01;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            resetPinN <= 1'b1;
        end else begin
            resetPinN <= !(fire || (pulseCnt_reg > 8'h01));
        end
    end
endmodule : wdc_reset_pulse

/* logic/wdc_watchdog.sv */
`include "wdc_map.svh"

module wdc_watchdog #(
    parameter int STEP_CYCLES = `WDC_STEP_CYCLES,
    parameter int PULSE_CYCLES = `WDC_PULSE_CYCLES
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic resetn,
    // Register port.
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdata,
    // Options and pins.
    input wire logic activationSourceOption,
    input wire logic externalStopControlOption,
    input wire logic nmiPin,
    // Core low power handshake.
    input wire logic stopInstr,
    input wire logic wakeInterrupt,
    output logic enterStop,
    output logic enterWait,
    output logic stopped,
    // Reset request and activation status.
    output logic resetPinN,
    output logic watchdogActive
);
    logic [6:0] count_reg;
    logic act_reg;
    wdc_pkg::wdc_state_t state_reg;
    wdc_pkg::wdc_stop_t stopKind;
    logic hit;
    logic ctrlWrite;
    logic stepPulse;
    logic fire;
    logic [7:0] regImage;

    // Map register bits to the counter, counter LSB at bit 7.
    function automatic logic [6:0] reg_to_count(input logic [7:0] r);
        logic [6:0] c;
        c = 7'h00;
        for (int i = 0; i < 6; i++) begin
            c[i] = r[7 - i];
        end
        c[6] = r[`WDC_SOFT_RESET_BIT];
        return c;
    endfunction : reg_to_count

    function automatic logic [7:0] count_to_reg(input logic [6:0] c, input logic a);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 6; i++) begin
            r[7 - i] = c[i];
        end
        r[`WDC_SOFT_RESET_BIT] = c[6];
        r[`WDC_ACT_BIT] = a;
        return r;
    endfunction : count_to_reg

    assign hit = (regAddr == `WDC_CTRL_ADDR);
    assign ctrlWrite = regWrite && hit;
    assign watchdogActive = act_reg || activationSourceOption;

    // Hardware option forces the bit high; the software option latches a 1 until reset.
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            act_reg <= 1'b0;
        end else if (activationSourceOption) begin
            act_reg <= 1'b1;
        end else if (ctrlWrite && regWdata[`WDC_ACT_BIT]) begin
            act_reg <= 1'b1;
        end
    end

    // Stop decision, combinational so the core sees it in the same cycle.
    always_comb begin
        if (!watchdogActive) begin
            stopKind = wdc_pkg::WDC_STOP_NORMAL;
        end else if (!externalStopControlOption) begin
            stopKind = wdc_pkg::WDC_STOP_AS_WAIT;
        end else if (!nmiPin) begin
            stopKind = wdc_pkg::WDC_STOP_AS_WAIT;
        end else begin
            stopKind = wdc_pkg::WDC_STOP_FREEZE;
        end
    end

    assign enterStop = stopInstr && (stopKind != wdc_pkg::WDC_STOP_AS_WAIT);
    assign enterWait = stopInstr && (stopKind == wdc_pkg::WDC_STOP_AS_WAIT);
    assign stopped = (state_reg == wdc_pkg::WDC_FROZEN);

    // Frozen only for a real stop; the free timer of an inactive watchdog also halts
    // in stop since the core clock is gone then.
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            state_reg <= wdc_pkg::WDC_RUN;
        end else begin
            unique case (state_reg)
                wdc_pkg::WDC_RUN: begin
                    if (enterStop) begin
                        state_reg <= wdc_pkg::WDC_FROZEN;
                    end
                end
                wdc_pkg::WDC_FROZEN: begin
                    if (wakeInterrupt) begin
                        state_reg <= wdc_pkg::WDC_RUN;
                    end
                end
                default: begin
                    state_reg <= wdc_pkg::WDC_RUN;
                end
            endcase
        end
    end

    wdc_step_divider #(
        .STEP_CYCLES(STEP_CYCLES)
    ) u_wdc_step_divider (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .run(state_reg == wdc_pkg::WDC_RUN),
        .restart(ctrlWrite),
        .stepPulse(stepPulse)
    );

    // A write beats a decrement in the same cycle, so the new timeout is never shortened.
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            count_reg <= reg_to_count(`WDC_CTRL_RESET);
        end else if (ctrlWrite) begin
            count_reg <= reg_to_count(regWdata);
        end else if (stepPulse) begin
            count_reg <= count_reg - 7'h01;
        end
    end

    // Soft reset bit clear while active, by write or by countdown.
    assign fire = watchdogActive && !count_reg[6];

    wdc_reset_pulse #(
        .PULSE_CYCLES(PULSE_CYCLES)
    ) u_wdc_reset_pulse (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .fire(fire),
        .resetPinN(resetPinN)
    );

    // Reads see the live count; a read across a step is the reason software reads twice.
    assign regImage = count_to_reg(count_reg, watchdogActive);
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            regRdata <= 8'h00;
        end else if (regRead && hit) begin
            regRdata <= regImage;
        end else begin
            regRdata <= 8'h00;
        end
    end
endmodule : wdc_watchdog

/* verification/wdc_watchdog_props.sv */
module wdc_watchdog_props (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic resetn,
    // Register port.
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regRdata,
    // Options, pins and status.
    input wire logic activationSourceOption,
    input wire logic externalStopControlOption,
    input wire logic nmiPin,
    input wire logic stopInstr,
    input wire logic wakeInterrupt,
    input wire logic enterStop,
    input wire logic enterWait,
    input wire logic stopped,
    input wire logic resetPinN,
    input wire logic watchdogActive
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    sequence pulse_s;
        !resetPinN [*2];
    endsequence
    sequence freeze_s;
        enterStop ##1 stopped;
    endsequence
    a_stop_normal: assert property (
        stopInstr && !watchdogActive |-> enterStop && !enterWait) else $error("stop lost");
    a_stop_as_wait: assert property (
        stopInstr && watchdogActive && !externalStopControlOption |-> enterWait && !enterStop)
        else $error("stop not wait");
    a_stop_nmi_low: assert property (
        stopInstr && watchdogActive && externalStopControlOption && !nmiPin |-> enterWait)
        else $error("stop not wait on low input");
    a_stop_freeze: assert property (
        stopInstr && watchdogActive && externalStopControlOption && nmiPin |-> freeze_s)
        else $error("no freeze");
    a_wake_resume: assert property (
        stopped && wakeInterrupt && !stopInstr |=> !stopped) else $error("no resume");
    a_read_quiet: assert property (
        !(regRead && regAddr == 8'hD8) |=> regRdata == 8'h00) else $error("stray read data");
    a_hw_active: assert property (
        activationSourceOption |-> watchdogActive) else $error("hardware option inactive");
    a_read_active: assert property (
        regRead && regAddr == 8'hD8 |=> regRdata[0] == $past(watchdogActive))
        else $error("activation bit misread");
    a_act_sticky: assert property (
        watchdogActive |=> watchdogActive) else $error("activation cleared");
    a_idle_quiet: assert property (
        !watchdogActive |-> resetPinN) else $error("reset while inactive");
    a_soft_reset: assert property (
        regWrite && regAddr == 8'hD8 && !regWdata[1] && watchdogActive |-> ##[1:3] pulse_s)
        else $error("no soft reset");
    a_pulse_hold: assert property (
        $fell(resetPinN) |-> pulse_s) else $error("pulse too short");
endmodule : wdc_watchdog_props

bind wdc_watchdog wdc_watchdog_props u_wdc_watchdog_props (.*);

/* verification/tb_wdc_watchdog.sv */
module tb_wdc_watchdog;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWdata = 8'h00;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic activationSourceOption = 1'b0;
    logic externalStopControlOption = 1'b0;
    logic nmiPin = 1'b0;
    logic stopInstr = 1'b0;
    logic wakeInterrupt = 1'b0;
    logic [7:0] regRdata;
    logic enterStop, enterWait, stopped, resetPinN, watchdogActive;
    int n_mismatch = 0;
    int check_count = 0;
    int k;
    always #12.5 sys_clk = ~sys_clk;
    // Short counts keep the run brief; every expectation below assumes them.
    wdc_watchdog #(.STEP_CYCLES(8), .PULSE_CYCLES(3)) u_wdc_watchdog (.*);
    function automatic logic [7:0] img(input logic [6:0] c, input logic act);
        return {c[0], c[1], c[2], c[3], c[4], c[5], c[6], act};
    endfunction : img
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            n_mismatch++;
        end
    endtask : chk
    task automatic wr(input logic [7:0] d, input logic [7:0] a = 8'hD8);
        @(posedge sys_clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge sys_clk);
        regWrite <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] exp, input logic [7:0] a = 8'hD8);
        @(posedge sys_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge sys_clk);
        regRead <= 1'b0;
        #1 chk(regRdata, exp);
    endtask : rd
    task automatic stp(input logic ext, nmi, st, wt);
        @(posedge sys_clk);
        externalStopControlOption <= ext;
        nmiPin <= nmi;
        stopInstr <= 1'b1;
        #1 chk({6'h00, enterStop, enterWait}, {6'h00, st, wt});
        @(posedge sys_clk);
        stopInstr <= 1'b0;
        #1 chk({7'h00, stopped}, {7'h00, st});
    endtask : stp
    task automatic wake();
        @(posedge sys_clk);
        wakeInterrupt <= 1'b1;
        @(posedge sys_clk);
        wakeInterrupt <= 1'b0;
        #1 chk({7'h00, stopped}, 8'h00);
    endtask : wake
    task automatic rst(input logic hw);
        @(posedge sys_clk);
        resetn <= 1'b0;
        activationSourceOption <= hw;
        repeat (3) @(posedge sys_clk);
        resetn <= 1'b1;
    endtask : rst
    task automatic close_out();
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : close_out
    initial begin
        repeat (3000) @(posedge sys_clk);
        n_mismatch++;
        close_out();
    end
    initial begin
        rst(1'b0);
        rd(8'hFE);
        chk({7'h00, watchdogActive}, 8'h00);
        rd(8'h00, 8'hD0);
        wr(8'h00, 8'hD7);
        rd(8'hFE);
        stp(1'b0, 1'b0, 1'b1, 1'b0);
        wake();
        // One past zero shows the inactive count wraps instead of resetting.
        wr(img(7'h01, 1'b0));
        repeat (26) @(posedge sys_clk);
        rd(img(7'h7E, 1'b0));
        // A second matching read is what software needs before trusting the timer.
        rd(img(7'h7E, 1'b0));
        wr(img(7'h7F, 1'b1));
        rd(8'hFF);
        wr(8'hFE);
        rd(8'hFF);
        stp(1'b0, 1'b0, 1'b0, 1'b1);
        stp(1'b1, 1'b0, 1'b0, 1'b1);
        wr(img(7'h40, 1'b1));
        stp(1'b1, 1'b1, 1'b1, 1'b0);
        repeat (40) @(posedge sys_clk);
        rd(img(7'h40, 1'b1));
        wake();
        chk({7'h00, resetPinN}, 8'h01);
        k = 0;
        while (resetPinN !== 1'b0 && k < 20) begin
            @(posedge sys_clk);
            k++;
        end
        #1 chk({7'h00, resetPinN}, 8'h00);
        rst(1'b0);
        rd(8'hFE);
        wr(8'hFF);
        wr(8'hFD);
        repeat (3) @(posedge sys_clk);
        #1 chk({7'h00, resetPinN}, 8'h00);
        rst(1'b1);
        chk({7'h00, watchdogActive}, 8'h01);
        wr(8'hFE);
        rd(8'hFF);
        close_out();
    end
endmodule : tb_wdc_watchdog
